// ==== verilog/rsc_pkg.sv ====
/*
 * Shared constants, state codes and state structs of the two-wire Repeated
 * Start sequencer with collision watch.
 * Assumes a host clock domain and a separate free-running link clock domain.
 */
package rsc_pkg;

	localparam int RATE_W = 8;
	localparam logic [RATE_W-1:0] RATE_RESET = 8'h00;
	localparam logic [RATE_W-1:0] COUNT_ZERO = 8'h00;
	localparam logic [RATE_W-1:0] COUNT_STEP = 8'h01;
	localparam logic SYNC_RESET = 1'b1;
	localparam logic LINE_LOW = 1'b0;

	typedef enum logic [2:0] {
		L_IDLE = 3'h0,
		L_SDA_REL = 3'h1,
		L_SCL_REL = 3'h2,
		L_HOLD_HI = 3'h3,
		L_HOLD_LO = 3'h4
	} rsc_lstate_e;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} rsc_sync_s;

	typedef struct packed {
		logic busy;
		logic done;
		logic coll_flag;
		logic start;
		logic [RATE_W-1:0] rate;
	} rsc_host_s;

	typedef struct packed {
		rsc_lstate_e state;
		logic [RATE_W-1:0] count;
		logic sda_oe;
		logic scl_oe;
		logic done_p;
		logic coll_p;
	} rsc_link_s;

	typedef struct packed {
		logic scl;
		logic sda;
	} rsc_lines_s;

endpackage

// ==== verilog/rsc_pin_sync.sv ====
/*
 * Three-stage synchroniser for one level that comes from another clock.
 * Assumes the input may change at any time relative to clk.
 */
`timescale 1ns/1ns
module rsc_pin_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic din,
	output logic dout
);

	rsc_pkg::rsc_sync_s st_reg;
	rsc_pkg::rsc_sync_s st_next;

	always_comb begin
		st_next = st_reg;
		st_next.s1 = din;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		// The level only moves once the last two stages agree.
		if (st_reg.s2 == st_reg.s3) begin
			st_next.level = st_reg.s3;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= {4{rsc_pkg::SYNC_RESET}};
		end else begin
			st_reg <= st_next;
		end
	end

	assign dout = st_reg.level;

endmodule

// ==== verilog/rsc_evt_cross.sv ====
/*
 * Carries single-cycle events from one clock domain to another by a toggle.
 * Assumes events are spaced by several destination clock periods.
 */
`timescale 1ns/1ns
module rsc_evt_cross (
	input wire logic src_clk,
	input wire logic src_reset,
	input wire logic src_pulse,
	input wire logic dst_clk,
	input wire logic dst_reset,
	output logic dst_pulse
);

	logic tgl_reg;
	logic tgl_next;
	logic tgl_sync;
	logic prev_reg;
	logic prev_next;

	always_comb begin
		tgl_next = tgl_reg ^ src_pulse;
	end

	// The toggle resets to the synchroniser's reset level, so no false event follows reset.
	always_ff @(posedge src_clk) begin
		if (src_reset) begin
			tgl_reg <= rsc_pkg::SYNC_RESET;
		end else begin
			tgl_reg <= tgl_next;
		end
	end

	rsc_pin_sync u_sync (
		.clk(dst_clk),
		.reset(dst_reset),
		.din(tgl_reg),
		.dout(tgl_sync)
	);

	always_comb begin
		prev_next = tgl_sync;
	end

	// The synchroniser resets high, so the edge register does too.
	always_ff @(posedge dst_clk) begin
		if (dst_reset) begin
			prev_reg <= rsc_pkg::SYNC_RESET;
		end else begin
			prev_reg <= prev_next;
		end
	end

	assign dst_pulse = tgl_sync ^ prev_reg;

endmodule

// ==== verilog/rsc_repeated_start.sv ====
/*
 * Repeated Start generator for a two-wire bus master, with collision watch.
 * The host side runs on clk; the bus side runs on link_clk, whose period is
 * the time base of the baud-rate counter. Bus lines are open drain: the
 * outputs are always low and the enables pull the wire down.
 * Assumes external pull-ups and a testbench that resolves the wires.
 */
`timescale 1ns/1ns
module rsc_repeated_start (
	input wire logic clk,
	input wire logic reset,
	input wire logic link_clk,
	input wire logic link_reset,
	input wire logic rs_req,
	input wire logic [rsc_pkg::RATE_W-1:0] rate_reload_value,
	input wire logic coll_clear,
	output logic rs_ready,
	output logic rs_busy,
	output logic rs_done,
	output logic coll_flag,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);

	rsc_pkg::rsc_host_s h_reg;
	rsc_pkg::rsc_host_s h_next;
	rsc_pkg::rsc_link_s l_reg;
	rsc_pkg::rsc_link_s l_next;
	rsc_pkg::rsc_lines_s raw_lines;
	rsc_pkg::rsc_lines_s lines;
	logic go_link;
	logic done_host;
	logic coll_host;
	logic expired;

	// Host domain: accepts a request and keeps the status seen by software.

	always_comb begin
		h_next = h_reg;
		h_next.done = 1'b0;
		h_next.start = 1'b0;
		if (rs_req && !h_reg.busy) begin
			// The rate stays frozen while busy, so the link side may read it.
			h_next.rate = rate_reload_value;
			h_next.busy = 1'b1;
			h_next.start = 1'b1;
		end
		if (done_host) begin
			h_next.busy = 1'b0;
			h_next.done = 1'b1;
		end
		if (coll_clear) begin
			h_next.coll_flag = 1'b0;
		end
		// A collision arriving with a clear still sets the flag.
		if (coll_host) begin
			h_next.busy = 1'b0;
			h_next.coll_flag = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			h_reg <= '{busy: 1'b0, done: 1'b0, coll_flag: 1'b0, start: 1'b0,
				rate: rsc_pkg::RATE_RESET};
		end else begin
			h_reg <= h_next;
		end
	end

	assign rs_ready = !h_reg.busy;
	assign rs_busy = h_reg.busy;
	assign rs_done = h_reg.done;
	assign coll_flag = h_reg.coll_flag;

	// Crossings between the two domains.

	rsc_evt_cross u_go (
		.src_clk(clk),
		.src_reset(reset),
		.src_pulse(h_reg.start),
		.dst_clk(link_clk),
		.dst_reset(link_reset),
		.dst_pulse(go_link)
	);

	rsc_evt_cross u_done (
		.src_clk(link_clk),
		.src_reset(link_reset),
		.src_pulse(l_reg.done_p),
		.dst_clk(clk),
		.dst_reset(reset),
		.dst_pulse(done_host)
	);

	rsc_evt_cross u_coll (
		.src_clk(link_clk),
		.src_reset(link_reset),
		.src_pulse(l_reg.coll_p),
		.dst_clk(clk),
		.dst_reset(reset),
		.dst_pulse(coll_host)
	);

	// Bus lines are sampled on the link clock.

	assign raw_lines.scl = scl_i;
	assign raw_lines.sda = sda_i;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_line
			rsc_pin_sync u_line (
				.clk(link_clk),
				.reset(link_reset),
				.din(raw_lines[gi]),
				.dout(lines[gi])
			);
		end
	endgenerate

	// Link domain: the Repeated Start sequence itself.

	assign expired = (l_reg.count == rsc_pkg::COUNT_ZERO);

	always_comb begin
		l_next = l_reg;
		l_next.done_p = 1'b0;
		l_next.coll_p = 1'b0;
		if (!expired) begin
			l_next.count = l_reg.count - rsc_pkg::COUNT_STEP;
		end
		unique case (l_reg.state)
			rsc_pkg::L_IDLE: begin
				if (go_link) begin
					// SDA floats high while SCL is still held low.
					l_next.sda_oe = 1'b0;
					l_next.scl_oe = 1'b1;
					l_next.count = h_reg.rate;
					l_next.state = rsc_pkg::L_SDA_REL;
				end
			end
			rsc_pkg::L_SDA_REL: begin
				if (expired) begin
					l_next.scl_oe = 1'b0;
					l_next.state = rsc_pkg::L_SCL_REL;
				end
			end
			rsc_pkg::L_SCL_REL: begin
				if (lines.scl) begin
					if (!lines.sda) begin
						// Another master sends a zero bit.
						l_next.coll_p = 1'b1;
						l_next.state = rsc_pkg::L_IDLE;
					end else begin
						l_next.count = h_reg.rate;
						l_next.state = rsc_pkg::L_HOLD_HI;
					end
				end
			end
			rsc_pkg::L_HOLD_HI: begin
				// SDA falling here is tolerated; only SCL falling counts.
				if (!lines.scl) begin
					// Another master sends a one bit.
					l_next.coll_p = 1'b1;
					l_next.sda_oe = 1'b0;
					l_next.scl_oe = 1'b0;
					l_next.state = rsc_pkg::L_IDLE;
				end else if (expired) begin
					// SDA is pulled low even if already low from afar.
					l_next.sda_oe = 1'b1;
					l_next.count = h_reg.rate;
					l_next.state = rsc_pkg::L_HOLD_LO;
				end
			end
			rsc_pkg::L_HOLD_LO: begin
				if (expired) begin
					l_next.scl_oe = 1'b1;
					l_next.done_p = 1'b1;
					l_next.state = rsc_pkg::L_IDLE;
				end
			end
			default: begin
				l_next.sda_oe = 1'b0;
				l_next.scl_oe = 1'b0;
				l_next.state = rsc_pkg::L_IDLE;
			end
		endcase
	end

	always_ff @(posedge link_clk) begin
		if (link_reset) begin
			l_reg <= '{state: rsc_pkg::L_IDLE, count: rsc_pkg::COUNT_ZERO,
				sda_oe: 1'b0, scl_oe: 1'b0, done_p: 1'b0, coll_p: 1'b0};
		end else begin
			l_reg <= l_next;
		end
	end

	assign scl_o = rsc_pkg::LINE_LOW;
	assign sda_o = rsc_pkg::LINE_LOW;
	assign scl_oe = l_reg.scl_oe;
	assign sda_oe = l_reg.sda_oe;

endmodule

// ==== tb/rsc_chk.sv ====
/*
 * Port checker of the Repeated Start sequencer, bound to its top module.
 * Assumes the rate value is held steady while a sequence runs.
 */
`timescale 1ns/1ns
module rsc_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic link_clk,
	input wire logic link_reset,
	input wire logic rs_req,
	input wire logic [rsc_pkg::RATE_W-1:0] rate_reload_value,
	input wire logic coll_clear,
	input wire logic rs_ready,
	input wire logic rs_busy,
	input wire logic rs_done,
	input wire logic coll_flag,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe
);
	logic [8:0] held_cnt;
	always_ff @(posedge link_clk) begin
		held_cnt <= (link_reset || !sda_oe || scl_oe) ? 9'h000 : held_cnt + 9'h001;
	end
	a_take_req: assert property (@(posedge clk) disable iff (reset)
		rs_req && !rs_busy |=> rs_busy) else $error("request not taken");
	a_done_pulse: assert property (@(posedge clk) disable iff (reset)
		rs_done |=> !rs_done) else $error("done longer than one cycle");
	a_done_lines: assert property (@(posedge clk) disable iff (reset)
		rs_done |-> scl_oe && sda_oe && !rs_busy) else $error("done without lines low");
	a_coll_lines: assert property (@(posedge clk) disable iff (reset)
		$rose(coll_flag) |-> !scl_oe && !sda_oe) else $error("collision kept lines");
	a_coll_idle: assert property (@(posedge clk) disable iff (reset)
		coll_flag && !rs_busy |-> !scl_oe && !sda_oe) else $error("lines held after collision");
	a_coll_sticky: assert property (@(posedge clk) disable iff (reset)
		coll_flag && !coll_clear |=> coll_flag) else $error("collision flag lost");
	a_scl_release: assert property (@(posedge link_clk) disable iff (link_reset)
		$fell(scl_oe) |-> !sda_oe) else $error("scl released with sda low");
	a_sda_drive: assert property (@(posedge link_clk) disable iff (link_reset)
		$rose(sda_oe) |-> !scl_oe && scl_i) else $error("sda driven without scl high");
	a_final_count: assert property (@(posedge link_clk) disable iff (link_reset)
		$rose(scl_oe) && sda_oe |-> held_cnt + 9'h001 >= {1'b0, rate_reload_value})
		else $error("final count too short");
	c_done: cover property (@(posedge clk) disable iff (reset) rs_done);
	c_coll: cover property (@(posedge clk) disable iff (reset) $rose(coll_flag));
	c_sda: cover property (@(posedge link_clk) disable iff (link_reset) $rose(sda_oe));
endmodule
bind rsc_repeated_start rsc_chk i_rsc_chk (.clk, .reset, .link_clk, .link_reset, .rs_req,
	.rate_reload_value, .coll_clear, .rs_ready, .rs_busy, .rs_done, .coll_flag, .scl_i,
	.scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe);

// ==== tb/rsc_far_master.sv ====
/*
 * Second bus master: quiet, holds SDA low, grabs SCL, or pulls SDA late.
 * Assumes pulled-up wires resolved by the bench and mode set before a start.
 */
`timescale 1ns/1ns
module rsc_far_master (
	input wire logic link_clk,
	input wire logic [1:0] mode,
	input wire logic scl,
	input wire logic sda_oe,
	output logic scl_pd,
	output logic sda_pd
);
	logic [3:0] hi_cnt;
	logic grab;
	logic armed;
	// The far master acts six cycles after SCL goes high, before the count expires.
	// It arms only once SCL has been low, so an idle released bus never triggers it early.
	always_ff @(posedge link_clk) begin
		armed <= (mode != 2'h0) && (armed || !scl);
		hi_cnt <= (armed && scl && !sda_oe && mode != 2'h0) ? hi_cnt + 4'h1 : 4'h0;
		grab <= (mode != 2'h0) && (grab || hi_cnt == 4'h6);
	end
	assign scl_pd = (mode == 2'h2) && grab;
	assign sda_pd = (mode == 2'h1) || ((mode == 2'h3) && grab);
endmodule

// ==== tb/tb_top.sv ====
/*
 * Bench of the Repeated Start sequencer against a second bus master.
 * Assumes pulled-up bus wires and a free link clock unrelated to clk.
 */
`timescale 1ns/1ns
module tb_top;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic reset = 1'b1;
	logic link_reset = 1'b1;
	logic rs_req = 1'b0;
	logic coll_clear = 1'b0;
	logic [rsc_pkg::RATE_W-1:0] rate = 8'h00;
	logic [1:0] mode = 2'h0;
	logic rs_ready, rs_busy, rs_done, coll_flag, scl_oe, sda_oe, scl_pd, sda_pd;
	logic scl_o, sda_o;
	wire logic scl = (scl_oe ? scl_o : 1'b1) && !scl_pd;
	wire logic sda = (sda_oe ? sda_o : 1'b1) && !sda_pd;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	rsc_repeated_start i_rsc_repeated_start (.clk, .reset, .link_clk, .link_reset, .rs_req,
		.rate_reload_value(rate), .coll_clear, .rs_ready, .rs_busy, .rs_done, .coll_flag,
		.scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
	rsc_far_master i_rsc_far_master (.link_clk, .mode, .scl, .sda_oe, .scl_pd, .sda_pd);
	initial forever #2 clk = !clk;
	initial begin
		#3;
		forever #16 link_clk = !link_clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	function automatic logic exp_coll(input logic [1:0] m);
		return m == 2'h1 || m == 2'h2;
	endfunction
	// Three full counts to finish, at least one before a collision; 8 clk per link cycle.
	function automatic logic [15:0] min_clk(input logic [1:0] m, input logic [7:0] r);
		return exp_coll(m) ? {8'h00, r} * 16'h0008 : {8'h00, r} * 16'h0018;
	endfunction
	task automatic run(input logic [1:0] m, input logic [7:0] r);
		logic [15:0] t;
		t = 16'h0003;
		mode <= m;
		rate <= r;
		@(posedge clk);
		rs_req <= 1'b1;
		@(posedge clk);
		rs_req <= 1'b0;
		@(posedge clk);
		check(rs_ready, 1'b0);
		rs_req <= 1'b1;
		@(posedge clk);
		rs_req <= 1'b0;
		while (rs_done !== 1'b1 && coll_flag !== 1'b1 && t < 16'h2000) begin
			@(posedge clk);
			t++;
		end
		check(t < 16'h2000, 1'b1);
		check(coll_flag, exp_coll(m));
		check(t >= min_clk(m, r), 1'b1);
		check({scl_oe, sda_oe}, exp_coll(m) ? 2'h0 : 2'h3);
		check({scl, sda}, exp_coll(m) ? {m != 2'h2, m != 2'h1} : 2'h0);
		repeat (40) @(posedge clk);
		check(rs_busy, 1'b0);
		check(coll_flag, exp_coll(m));
		coll_clear <= 1'b1;
		@(posedge clk);
		coll_clear <= 1'b0;
		mode <= 2'h0;
		repeat (2) @(posedge clk);
		check(coll_flag, 1'b0);
		repeat (60) @(posedge clk);
		$display("test mode %0d rate %0d done", m, r);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		void'($urandom(90));
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		repeat (24) @(posedge clk);
		link_reset <= 1'b0;
		repeat (40) @(posedge clk);
		run(2'h0, 8'h00);
		run(2'h0, 8'hFF);
		for (int i = 0; i < 12; i++) begin
			run(2'(i % 4), 8'h08 + 8'($urandom % 16));
		end
		close_out();
	end
endmodule
